//--- design/dcv_pkg.sv
// Behaviour
// R1: Host loads every DAC filter coefficient over the control port before DAC power-up.
// R2: After pin or software reset, unity passthrough coefficients are copied from ROM.
// R3: Boot copy lasts 100 us; host avoids coefficient pages 8 to 15 meanwhile.
// R4: Host keeps the DAC powered down until configuration writes are complete.
// R5: Outside adaptive mode, host follows the update sequence for coefficient changes.
// R6: Adaptive mode lets coefficients be rewritten while the DAC stays powered.
// R7: Mono DAC input mux picks left, right or half their sum from page 0 reg 63.
// R8: Four digital mixers, each summing its inputs or passing one of them; the code's mixers output half the sum.
// R9: DAC output routes to headphone, speaker or both with separate volumes.
// R10: Analog volume keeps working and programmable while the DAC is powered down.
// R11: Headphone attenuation is the seven-bit field of page 1 reg 22.
// R12: Code 0 is 0 dB, about 0.5 dB per code, codes 117 to 127 maximum.
// R13: Headphone attenuation moves gradually toward a new setting by soft-stepping.
// R14: Soft-step pace comes from bits 1..0 of page 0 reg 63.
// R15: Page 1 reg 12 bit 2 connects the attenuator to the headphone amplifier.
// R16: Pace is one 0.125 dB step per sample, per two samples, or off.
// R17: During boot copy, coefficient writes are ignored and coefficient reads return zero.
`default_nettype none
package dcv_pkg;
	localparam int        CLK_MHZ        = 125;
	localparam int        BOOT_TIME_US   = 100;
	localparam int        BOOT_CYC       = BOOT_TIME_US * CLK_MHZ;
	localparam int        SAMPLE_HZ      = 48000;
	localparam int        SAMPLE_DIV     = (CLK_MHZ * 1000000) / SAMPLE_HZ;
	localparam int        COEF_DEPTH     = 32;
	localparam int        BIQUAD_BYTES   = 15;
	localparam int        FIFO_DEPTH     = 16;
	localparam int        SAMPLE_W       = 16;
	localparam logic [7:0] PAGE_REG      = 8'h00;
	localparam logic [7:0] P0_SOFT_RST   = 8'h01;
	localparam logic [7:0] P0_ADAPT      = 8'h02;
	localparam logic [7:0] P0_MIX_CFG    = 8'h03;
	localparam logic [7:0] P0_STATUS     = 8'h26;
	localparam logic [7:0] P0_MONO_CFG   = 8'h3F;
	localparam logic [7:0] P1_ROUTE      = 8'h0C;
	localparam logic [7:0] P1_HP_ATTEN   = 8'h16;
	localparam logic [7:0] P1_SPK_ATTEN  = 8'h2E;
	localparam logic [7:0] COEF_PAGE_LO  = 8'h08;
	localparam logic [7:0] COEF_PAGE_HI  = 8'h0F;
	localparam int        DAC_PWR_BIT    = 7;
	localparam int        ADAPT_BIT      = 2;
	localparam int        HP_ROUTE_BIT   = 2;
	localparam int        SPK_ROUTE_BIT  = 3;
	localparam int        SETTLED_BIT    = 4;
	localparam logic [6:0] ATTEN_MAX     = 7'h75;
	localparam logic [7:0] UNITY_MSB     = 8'h7F;
	localparam logic [7:0] UNITY_LSB     = 8'hFF;
	localparam logic [7:0] MONO_CFG_RST  = 8'h00;
	localparam logic [6:0] ATTEN_RST     = 7'h00;
	localparam logic [1:0] STEP_EVERY    = 2'h0;
	localparam logic [1:0] STEP_HALF     = 2'h1;
	localparam logic [1:0] MIX_A         = 2'h0;
	localparam logic [1:0] MIX_B         = 2'h1;
endpackage : dcv_pkg
`default_nettype wire

//--- design/dcv_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dcv_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,    // Clock
	input  wire logic             sys_rst, // Async reset
	input  wire logic             flush,   // Sync clear
	input  wire logic             in_valid,// Write request
	output logic                  in_ready,// Not full
	input  wire logic [WIDTH-1:0] in_data, // Write word
	output logic                  out_valid,// Not empty
	input  wire logic             out_ready,// Read request
	output logic      [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [AW:0]      cnt;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem[rp];

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wp        <= '0;
			rp        <= '0;
			cnt       <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else if (flush) begin
			wp        <= '0;
			rp        <= '0;
			cnt       <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wp <= AW'(wp + 1'b1);
			end
			if (pop) begin
				rp <= AW'(rp + 1'b1);
			end
			if (push && !pop) begin
				cnt       <= (AW+1)'(cnt + 1'b1);
				in_ready  <= (cnt != (AW+1)'(DEPTH - 1));
				out_valid <= 1'b1;
			end else if (pop && !push) begin
				cnt       <= (AW+1)'(cnt - 1'b1);
				in_ready  <= 1'b1;
				out_valid <= (cnt != (AW+1)'(1));
			end else begin
				in_ready  <= (cnt != (AW+1)'(DEPTH));
			end
		end
	end
endmodule : dcv_fifo
`default_nettype wire

//--- design/dcv_top.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dcv_top #(
	parameter int BOOT_CYCLES = dcv_pkg::BOOT_CYC
) (
	input  wire logic        mclk,        // 125 MHz clock
	input  wire logic        sys_rst,     // Async reset, pin
	input  wire logic [15:0] reg_addr,    // {unused, register}; page from reg 0
	input  wire logic [7:0]  reg_wdata,   // Write data
	input  wire logic        reg_wr,      // Write strobe
	input  wire logic        reg_rd,      // Read strobe
	output logic      [7:0]  reg_rdata,   // Read data, next cycle
	input  wire logic [15:0] in_left,     // Left sample
	input  wire logic [15:0] in_right,    // Right sample
	input  wire logic        in_valid,    // Sample pair valid
	output logic             in_ready,    // FIFO can accept
	output logic      [15:0] dac_sample,  // Mixed mono sample
	output logic             dac_valid,   // Sample valid
	input  wire logic        dac_ready,   // DAC takes sample
	output logic             dac_power,   // DAC power enable
	output logic      [6:0]  hp_atten,    // Applied hp attenuation
	output logic      [6:0]  spk_atten,   // Speaker attenuation
	output logic             hp_route,    // Attenuator to hp amp
	output logic             spk_route,   // Attenuator to spk amp
	output logic             boot_busy    // Coefficient copy active
);
	logic [7:0]  page_sel;
	logic [7:0]  mono_cfg;
	logic [7:0]  mix_cfg;
	logic        adaptive;
	logic [6:0]  hp_code;
	logic        soft_rst;
	logic [13:0] boot_cnt;
	logic [7:0]  coef_ram [dcv_pkg::COEF_DEPTH];
	logic [11:0] div_cnt;
	logic        div_tick;
	logic        half_phase;
	logic [8:0]  hp_q;
	logic [8:0]  hp_tgt;
	logic        step_tick;
	logic        wr_p0;
	logic        wr_p1;
	logic        coef_hit;
	logic        coef_we;
	logic [4:0]  coef_idx;
	logic [31:0] fifo_data;
	logic        fifo_valid;
	logic        pop;
	logic [15:0] mix0;
	logic [15:0] mix1;
	logic [15:0] mix2;
	logic [15:0] mix3;
	logic [6:0]  next_code;

	//********************
	// Address decode
	//********************
	assign wr_p0    = reg_wr && (page_sel == 8'h00);
	assign wr_p1    = reg_wr && (page_sel == 8'h01);
	assign coef_hit = (page_sel >= dcv_pkg::COEF_PAGE_LO)
		&& (page_sel <= dcv_pkg::COEF_PAGE_HI);
	assign coef_idx = reg_addr[4:0];
	// R17 lock during copy
	// R6 adaptive writes
	// Register 0 stays the page select on every page
	assign coef_we  = reg_wr && coef_hit && !boot_busy
		&& (reg_addr[7:0] != dcv_pkg::PAGE_REG)
		&& (adaptive || !dac_power);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= wr_p0 && (reg_addr[7:0] == dcv_pkg::P0_SOFT_RST)
				&& reg_wdata[0];
		end
	end

	//********************
	// Control registers
	//********************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			page_sel  <= 8'h00;
			mono_cfg  <= dcv_pkg::MONO_CFG_RST;
			mix_cfg   <= 8'h00;
			adaptive  <= 1'b0;
			hp_code   <= dcv_pkg::ATTEN_RST;
			spk_atten <= dcv_pkg::ATTEN_RST;
			hp_route  <= 1'b0;
			spk_route <= 1'b0;
		end else if (soft_rst) begin
			page_sel  <= 8'h00;
			mono_cfg  <= dcv_pkg::MONO_CFG_RST;
			mix_cfg   <= 8'h00;
			adaptive  <= 1'b0;
			hp_code   <= dcv_pkg::ATTEN_RST;
			spk_atten <= dcv_pkg::ATTEN_RST;
			hp_route  <= 1'b0;
			spk_route <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr[7:0] == dcv_pkg::PAGE_REG) begin
				page_sel <= reg_wdata;
			end else if (wr_p0 && reg_addr[7:0] == dcv_pkg::P0_MONO_CFG) begin
				mono_cfg <= reg_wdata;
			end else if (wr_p0 && reg_addr[7:0] == dcv_pkg::P0_MIX_CFG) begin
				mix_cfg <= reg_wdata;
			end else if (wr_p0 && reg_addr[7:0] == dcv_pkg::P0_ADAPT) begin
				adaptive <= reg_wdata[dcv_pkg::ADAPT_BIT];
			end else if (wr_p1 && reg_addr[7:0] == dcv_pkg::P1_ROUTE) begin
				// R15 hp connect
				// R9 independent routes
				hp_route  <= reg_wdata[dcv_pkg::HP_ROUTE_BIT];
				spk_route <= reg_wdata[dcv_pkg::SPK_ROUTE_BIT];
			end else if (wr_p1 && reg_addr[7:0] == dcv_pkg::P1_HP_ATTEN) begin
				// R11 hp code
				hp_code <= reg_wdata[6:0];
			end else if (wr_p1 && reg_addr[7:0] == dcv_pkg::P1_SPK_ATTEN) begin
				spk_atten <= reg_wdata[6:0];
			end
		end
	end

	assign dac_power = mono_cfg[dcv_pkg::DAC_PWR_BIT];

	//********************
	// Boot copy
	//********************
	function automatic logic [7:0] rom_byte(input logic [4:0] idx);
		int pos;
		pos = int'(idx) % dcv_pkg::BIQUAD_BYTES;
		if (pos == 0) begin
			rom_byte = dcv_pkg::UNITY_MSB;
		end else if (pos < 3) begin
			rom_byte = dcv_pkg::UNITY_LSB;
		end else begin
			rom_byte = 8'h00;
		end
	endfunction : rom_byte

	// R3 copy window
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			boot_cnt  <= 14'h0000;
			boot_busy <= 1'b1;
		end else if (soft_rst) begin
			boot_cnt  <= 14'h0000;
			boot_busy <= 1'b1;
		end else if (boot_busy) begin
			boot_cnt  <= 14'(boot_cnt + 1'b1);
			boot_busy <= (boot_cnt != 14'(BOOT_CYCLES - 1));
		end
	end

	// R2 load unity set
	always_ff @(posedge mclk) begin
		if (boot_busy && boot_cnt < 14'(dcv_pkg::COEF_DEPTH)) begin
			coef_ram[boot_cnt[4:0]] <= rom_byte(boot_cnt[4:0]);
		end else if (coef_we) begin
			coef_ram[coef_idx] <= reg_wdata;
		end
	end

	//********************
	// Read port
	//********************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr[7:0] == dcv_pkg::PAGE_REG) begin
			reg_rdata <= page_sel;
		end else if (coef_hit) begin
			// R17 blocked read
			reg_rdata <= boot_busy ? 8'h00 : coef_ram[coef_idx];
		end else if (page_sel == 8'h00) begin
			if (reg_addr[7:0] == dcv_pkg::P0_MONO_CFG) begin
				reg_rdata <= mono_cfg;
			end else if (reg_addr[7:0] == dcv_pkg::P0_MIX_CFG) begin
				reg_rdata <= mix_cfg;
			end else if (reg_addr[7:0] == dcv_pkg::P0_ADAPT) begin
				reg_rdata <= {5'h00, adaptive, 2'h0};
			end else if (reg_addr[7:0] == dcv_pkg::P0_STATUS) begin
				reg_rdata <= {3'h0, hp_q == hp_tgt, 3'h0, boot_busy};
			end else begin
				reg_rdata <= 8'h00;
			end
		end else if (page_sel == 8'h01) begin
			if (reg_addr[7:0] == dcv_pkg::P1_ROUTE) begin
				reg_rdata <= {4'h0, spk_route, hp_route, 2'h0};
			end else if (reg_addr[7:0] == dcv_pkg::P1_HP_ATTEN) begin
				reg_rdata <= {1'b0, hp_code};
			end else if (reg_addr[7:0] == dcv_pkg::P1_SPK_ATTEN) begin
				reg_rdata <= {1'b0, spk_atten};
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	//********************
	// Sample path
	//********************
	dcv_fifo #(
		.WIDTH (32),
		.DEPTH (dcv_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.flush     (soft_rst),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   ({in_left, in_right}),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	// Stalls while DAC is off so the FIFO backs up to the source
	assign pop = fifo_valid && dac_power && (!dac_valid || dac_ready);

	function automatic logic [15:0] mix(input logic [15:0] a,
		input logic [15:0] b, input logic [1:0] mode);
		logic signed [16:0] sum;
		sum = 17'($signed(a)) + 17'($signed(b));
		if (mode == dcv_pkg::MIX_A) begin
			mix = a;
		end else if (mode == dcv_pkg::MIX_B) begin
			mix = b;
		end else begin
			mix = sum[16:1];
		end
	endfunction : mix

	// R7 mono input mux
	// R8 four mixers
	assign mix0 = mix(fifo_data[31:16], fifo_data[15:0], mono_cfg[5:4]);
	assign mix1 = mix(mix0, fifo_data[31:16], mix_cfg[1:0]);
	assign mix2 = mix(mix1, fifo_data[15:0], mix_cfg[3:2]);
	assign mix3 = mix(mix2, mix0, mix_cfg[5:4]);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_valid  <= 1'b0;
			dac_sample <= 16'h0000;
		end else if (soft_rst) begin
			dac_valid  <= 1'b0;
		end else if (pop) begin
			dac_valid  <= 1'b1;
			dac_sample <= mix3;
		end else if (dac_ready) begin
			dac_valid  <= 1'b0;
		end
	end

	//********************
	// Volume soft-step
	//********************
	// R10 internal pace without DAC
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt  <= 12'h000;
			div_tick <= 1'b0;
		end else begin
			div_tick <= (div_cnt == 12'(dcv_pkg::SAMPLE_DIV - 1));
			if (div_cnt == 12'(dcv_pkg::SAMPLE_DIV - 1)) begin
				div_cnt <= 12'h000;
			end else begin
				div_cnt <= 12'(div_cnt + 1'b1);
			end
		end
	end

	// R12 codes above 117 clamp to max
	assign next_code = (hp_code > dcv_pkg::ATTEN_MAX) ? dcv_pkg::ATTEN_MAX
		: hp_code;
	assign hp_tgt    = {next_code, 2'b00};
	// R14 pace field
	assign step_tick = (dac_power ? pop : div_tick)
		&& (mono_cfg[1:0] == dcv_pkg::STEP_EVERY
		|| (mono_cfg[1:0] == dcv_pkg::STEP_HALF && half_phase));

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			half_phase <= 1'b0;
		end else if (dac_power ? pop : div_tick) begin
			half_phase <= !half_phase;
		end
	end

	// R13 gradual move
	// R16 quarter-code steps
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hp_q <= 9'h000;
		end else if (soft_rst) begin
			hp_q <= 9'h000;
		end else if (mono_cfg[1]) begin
			hp_q <= hp_tgt;
		end else if (step_tick && hp_q < hp_tgt) begin
			hp_q <= 9'(hp_q + 1'b1);
		end else if (step_tick && hp_q > hp_tgt) begin
			hp_q <= 9'(hp_q - 1'b1);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hp_atten <= 7'h00;
		end else begin
			hp_atten <= hp_q[8:2];
		end
	end

	//********************
	// Checks
	//********************
	a_boot_end_time: assert property (@(posedge mclk) disable iff (sys_rst) // R3
		(boot_busy && boot_cnt == 14'(BOOT_CYCLES - 1) && !soft_rst)
		|=> !boot_busy)
		else $error("boot copy did not end on time");
	a_boot_unity_msb: assert property (@(posedge mclk) disable iff (sys_rst) // R2
		(boot_busy && boot_cnt == 14'h0000 && !soft_rst)
		|=> coef_ram[0] == dcv_pkg::UNITY_MSB)
		else $error("unity coefficient not loaded");
	a_coef_wr_lock: assert property (@(posedge mclk) disable iff (sys_rst) // R17
		(reg_wr && coef_hit && boot_busy
		&& (boot_cnt > 14'h001F || boot_cnt[4:0] != coef_idx))
		|=> coef_ram[$past(coef_idx)] == $past(coef_ram[coef_idx]))
		else $error("coefficient written during copy");
	a_coef_rd_lock: assert property (@(posedge mclk) disable iff (sys_rst) // R17
		(reg_rd && coef_hit && boot_busy && reg_addr[7:0] != 8'h00)
		|=> reg_rdata == 8'h00)
		else $error("coefficient read during copy");
	a_adapt_write: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		(reg_wr && coef_hit && !boot_busy && dac_power && adaptive
		&& reg_addr[7:0] != 8'h00)
		|=> coef_ram[$past(coef_idx)] == $past(reg_wdata))
		else $error("adaptive write lost");
	a_mux_average: assert property (@(posedge mclk) disable iff (sys_rst) // R7
		(pop && !soft_rst && mono_cfg[5:4] == 2'h2 && mix_cfg[5:0] == 6'h00)
		|=> dac_sample == 16'((17'($signed($past(fifo_data[31:16])))
		+ 17'($signed($past(fifo_data[15:0])))) >>> 1))
		else $error("mono mix wrong");
	a_step_hold: assert property (@(posedge mclk) disable iff (sys_rst) // R16
		(!step_tick && !mono_cfg[1] && !soft_rst) |=> $stable(hp_q))
		else $error("volume moved without a step");
	a_step_up_one: assert property (@(posedge mclk) disable iff (sys_rst) // R13
		(step_tick && !mono_cfg[1] && hp_q < hp_tgt && !soft_rst)
		|=> hp_q == 9'($past(hp_q) + 1'b1))
		else $error("volume step not one");
	a_half_pace: assert property (@(posedge mclk) disable iff (sys_rst) // R14
		(mono_cfg[1:0] == dcv_pkg::STEP_HALF && !half_phase) |-> !step_tick)
		else $error("half pace stepped too often");
	a_hp_connect: assert property (@(posedge mclk) disable iff (sys_rst) // R15
		(wr_p1 && reg_addr[7:0] == dcv_pkg::P1_ROUTE && !soft_rst)
		|=> hp_route == $past(reg_wdata[dcv_pkg::HP_ROUTE_BIT]))
		else $error("hp route not taken");
endmodule : dcv_top
`default_nettype wire

//--- dv/dcv_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Host processor on the register port
// ********************************
module dcv_host_model (
	input  wire logic        mclk,      // Clock
	input  wire logic        boot_busy, // Coefficient copy active
	input  wire logic [7:0]  reg_rdata, // Read data
	output logic      [15:0] reg_addr,  // Register address
	output logic      [7:0]  reg_wdata, // Write data
	output logic             reg_wr,    // Write strobe
	output logic             reg_rd     // Read strobe
);
	initial begin
		reg_addr  = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// One-cycle write strobe, an idle edge before each access
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= {8'h00, a};
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data are taken at the edge after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= {8'h00, a};
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		@(posedge mclk);
		d = reg_rdata;
	endtask : rd

	task automatic wait_boot(output int c);
		c = 0;
		while (boot_busy === 1'b1 && c < 1000) begin
			@(posedge mclk);
			c++;
		end
	endtask : wait_boot
endmodule : dcv_host_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int BOOT = 64;
	logic        mclk, sys_rst, reg_wr, reg_rd, in_valid, in_ready;
	logic        dac_valid, dac_ready, dac_power, hp_route, spk_route;
	logic        boot_busy;
	logic [15:0] reg_addr, in_left, in_right, dac_sample, last;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [6:0]  hp_atten, spk_atten;
	int          fails, tests_run, pops, t0;

	// ********************************
	// Clock, design and host
	// ********************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	dcv_top #(.BOOT_CYCLES(BOOT)) dcv_top_inst (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_left(in_left), .in_right(in_right),
		.in_valid(in_valid), .in_ready(in_ready), .dac_sample(dac_sample),
		.dac_valid(dac_valid), .dac_ready(dac_ready), .dac_power(dac_power),
		.hp_atten(hp_atten), .spk_atten(spk_atten), .hp_route(hp_route),
		.spk_route(spk_route), .boot_busy(boot_busy)
	);

	dcv_host_model dcv_host_model_inst (
		.mclk(mclk), .boot_busy(boot_busy), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd)
	);

	always @(posedge mclk) begin
		if (dac_valid === 1'b1 && dac_ready === 1'b1) begin
			pops++;
			last = dac_sample;
		end
	end

	// ********************************
	// Shared tasks
	// ********************************
	task automatic chk(input string n, input logic [15:0] e,
			input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic pw(input logic [7:0] p, input logic [7:0] r,
			input logic [7:0] d);
		dcv_host_model_inst.wr(8'h00, p);
		dcv_host_model_inst.wr(r, d);
	endtask : pw

	task automatic pr(input string n, input logic [7:0] p,
			input logic [7:0] r, input logic [7:0] e);
		logic [7:0] d;
		dcv_host_model_inst.wr(8'h00, p);
		dcv_host_model_inst.rd(r, d);
		chk(n, 16'(e), 16'(d));
	endtask : pr

	task automatic push(input int n, input logic [15:0] l,
			input logic [15:0] r);
		int k;
		k = 0;
		in_left  <= l;
		in_right <= r;
		in_valid <= 1'b1;
		while (k < n) begin
			@(posedge mclk);
			if (in_ready === 1'b1) k++;
		end
		in_valid <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask : push

	task automatic wait_boot_chk();
		int c;
		dcv_host_model_inst.wait_boot(c);
		chk("boot_len", 16'h0001, 16'(($time - t0) / 8 >= BOOT &&
			($time - t0) / 8 <= BOOT + 2));
	endtask : wait_boot_chk

	task automatic complete_run();
		if (fails == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_boot();
		chk("boot_busy", 16'h0001, 16'(boot_busy));
		pr("coef_busy", 8'h08, 8'h01, 8'h00);
		pw(8'h08, 8'h05, 8'h5A);
		wait_boot_chk();
		pr("rom0", 8'h08, 8'h1E, 8'h7F);
		pr("rom1", 8'h0F, 8'h01, 8'hFF);
		pr("rom5", 8'h08, 8'h05, 8'h00);
		// coefficients loaded while the DAC is still off
		pw(8'h09, 8'h05, 8'h5A);
		pr("coef_wr", 8'h0F, 8'h05, 8'h5A);
		pr("status", 8'h00, 8'h26, 8'h10);
		pr("unmapped", 8'h00, 8'h7E, 8'h00);
	endtask : t_boot

	task automatic t_route();
		logic [7:0] v[3] = '{8'h04, 8'h08, 8'h0C};
		foreach (v[i]) begin
			pw(8'h01, 8'h0C, v[i]);
			@(posedge mclk);
			chk("hp_route", 16'(v[i][2]), 16'(hp_route));
			chk("spk_route", 16'(v[i][3]), 16'(spk_route));
		end
		pw(8'h01, 8'h2E, 8'h33);
		@(posedge mclk);
		chk("spk_atten", 16'h0033, 16'(spk_atten));
	endtask : t_route

	task automatic t_mix();
		logic [7:0]  m[8] = '{8'h80, 8'h90, 8'hA0, 8'hB0,
			8'h90, 8'h80, 8'h80, 8'h90};
		logic [7:0]  c[8] = '{8'h00, 8'h00, 8'h00, 8'h00,
			8'h01, 8'h08, 8'h04, 8'h11};
		logic [15:0] e[8] = '{16'h1000, 16'h3000, 16'h2000, 16'h2000,
			16'h1000, 16'h2000, 16'h3000, 16'h3000};
		// the DAC is powered by the mono mux write, before the mixer write
		foreach (m[i]) begin
			pw(8'h00, 8'h3F, m[i]);
			pw(8'h00, 8'h03, c[i]);
			push(1, 16'h1000, 16'h3000);
			chk("dac_sample", e[i], last);
		end
		chk("dac_power", 16'h0001, 16'(dac_power));
	endtask : t_mix

	task automatic t_adapt();
		// coefficients change in play only in adaptive mode
		pw(8'h08, 8'h06, 8'hA5);
		pr("coef_lock", 8'h08, 8'h06, 8'h00);
		pw(8'h00, 8'h02, 8'h04);
		pw(8'h08, 8'h06, 8'hA5);
		pr("coef_adapt", 8'h08, 8'h06, 8'hA5);
		pw(8'h00, 8'h02, 8'h00);
	endtask : t_adapt

	task automatic t_step();
		pw(8'h00, 8'h3F, 8'h80);
		pw(8'h01, 8'h16, 8'h02);
		push(4, 16'h0000, 16'h0000);
		chk("hp_step1", 16'h0001, 16'(hp_atten));
		push(4, 16'h0000, 16'h0000);
		chk("hp_step2", 16'h0002, 16'(hp_atten));
		pw(8'h00, 8'h3F, 8'h81);
		pw(8'h01, 8'h16, 8'h03);
		push(4, 16'h0000, 16'h0000);
		chk("hp_half", 16'h0002, 16'(hp_atten));
		push(4, 16'h0000, 16'h0000);
		chk("hp_half2", 16'h0003, 16'(hp_atten));
		pw(8'h00, 8'h3F, 8'h82);
		pw(8'h01, 8'h16, 8'h7F);
		repeat (4) @(posedge mclk);
		chk("hp_max", 16'h0075, 16'(hp_atten));
		pw(8'h00, 8'h3F, 8'h83);
		pw(8'h01, 8'h16, 8'h00);
		repeat (4) @(posedge mclk);
		chk("hp_zero", 16'h0000, 16'(hp_atten));
		pw(8'h00, 8'h3F, 8'h00);
		pw(8'h01, 8'h16, 8'h01);
		repeat (2 * dcv_pkg::SAMPLE_DIV) @(posedge mclk);
		chk("hp_off_mid", 16'h0000, 16'(hp_atten));
		repeat (2 * dcv_pkg::SAMPLE_DIV + 20) @(posedge mclk);
		chk("hp_off_end", 16'h0001, 16'(hp_atten));
	endtask : t_step

	task automatic t_fifo();
		int k;
		int p0;
		k = 0;
		in_valid <= 1'b1;
		repeat (24) begin
			@(posedge mclk);
			if (in_ready === 1'b1) k++;
		end
		in_valid <= 1'b0;
		chk("fifo_fill", 16'd16, 16'(k));
		dac_ready <= 1'b0;
		p0 = pops;
		pw(8'h00, 8'h3F, 8'h80);
		repeat (10) @(posedge mclk);
		chk("stall_valid", 16'h0001, 16'(dac_valid));
		chk("stall_pops", 16'(p0), 16'(pops));
		dac_ready <= 1'b1;
		repeat (40) @(posedge mclk);
		chk("drain", 16'd16, 16'(pops - p0));
	endtask : t_fifo

	task automatic t_soft_rst();
		pw(8'h00, 8'h01, 8'h01);
		t0 = int'($time);
		repeat (3) @(posedge mclk);
		chk("srst_busy", 16'h0001, 16'(boot_busy));
		chk("srst_pwr", 16'h0000, 16'(dac_power));
		wait_boot_chk();
		pr("srst_cfg", 8'h00, 8'h3F, 8'h00);
		pr("srst_coef", 8'h0A, 8'h05, 8'h00);
		pr("srst_rom", 8'h08, 8'h0F, 8'h7F);
	endtask : t_soft_rst

	// ********************************
	// Main sequence and watchdog
	// ********************************
	initial begin
		fails = 0;
		tests_run = 0;
		pops = 0;
		sys_rst = 1'b1;
		in_valid = 1'b0;
		in_left = 16'h0000;
		in_right = 16'h0000;
		dac_ready = 1'b1;
		repeat (20) @(posedge mclk);
		chk("rst_ready", 16'h0000, 16'(in_ready));
		sys_rst <= 1'b0;
		t0 = int'($time);
		t_boot();
		t_route();
		t_mix();
		t_adapt();
		t_step();
		t_fifo();
		t_soft_rst();
		complete_run();
	end

	initial begin
		repeat (30000) @(posedge mclk);
		fails++;
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
